// file: core/ccs_pkg.sv
// Purpose: shared constants and carriers for the cpu clock switch control
// Assumes: byte-wide control registers written by one-cycle strobes
// Notes: frequencies are in kHz; counts derive from them in the top module
package ccs_pkg;
    // processor clock divider register fields
    localparam int unsigned DIV_LSB = 0;
    localparam int unsigned DIV_W = 3;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_MAX = 3'h4;
    localparam logic [4:0] DIV_DLY_BASE = 5'h10;
    // main clock mode register fields
    localparam int unsigned MCM_SEL_BIT = 0;
    localparam int unsigned MCM_STS_BIT = 1;
    localparam int unsigned MCM_HSEN_BIT = 2;
    localparam logic MCM_SEL_RST = 1'b0;
    localparam logic MCM_HSEN_RST = 1'b0;
    localparam logic SRC_INT_HS = 1'b0;
    localparam logic SRC_HS_SYS = 1'b1;
    // main oscillator control register
    localparam int unsigned MOC_STOP_BIT = 7;
    localparam logic MOC_STOP_RST = 1'b1;
    // internal oscillation mode register
    localparam int unsigned RCM_STOP_BIT = 0;
    localparam int unsigned RCM_RUN_BIT = 7;
    localparam logic RCM_STOP_RST = 1'b0;
    // default oscillator rates
    localparam int unsigned INT_HS_FREQ_KHZ = 1000;
    localparam int unsigned HS_SYS_FREQ_KHZ = 4000;
    localparam int unsigned MSW_CNT_W = 16;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } ccs_wr_t;

    typedef struct packed {
        logic wdt;
        logic tmr8_h0;
        logic tmr8_h1;
        logic evt_cnt;
        logic serial;
    } ccs_periph_en_t;

    typedef struct packed {
        logic tmr8_h0_use_t8out;
        logic tmr8_h1_use_lowspd;
        logic evt_cnt_use_pin;
        logic serial_use_t8out;
    } ccs_periph_sel_t;
endpackage : ccs_pkg

// file: core/ccs_clock_switch.sv
// Purpose: cpu clock divider and main system clock source switch
// Assumes: oscillator activity arrives as one-cycle ticks on clk_sys_i
// Notes: clocks are delivered as enables, so every switch is whole-tick clean
//
// Functional notes
// R1: cpu clock is main clock divided by field
// R2: old divider kept running until delay elapses
// R3: delay 16/8/4/2/1 cpu clocks by old setting
// R4: main source chosen by select bit zero
// R5: old main source kept during switchover delay
// R6: status bit one shows source in use
// R7: switch takes one plus twice ratio old clocks
// R8: ratio count truncated to an integer
// R9: software enables high-speed source before selecting it
// R10: high-speed enable changes only once per reset
// R11: stop internal oscillator only when status is one
// R12: stop external main clock only when status zero
// R13: peripheral source clocks limited to listed choices
// R14: external main clock stop flag at bit seven
// R15: internal oscillator stop bit zero, status bit seven
// R16: select zero internal, one high-speed, reset internal
// R17: switching never makes a short cpu clock pulse
`timescale 1ns/1ns
module ccs_clock_switch
    import ccs_pkg::*;
#(
    parameter int unsigned INT_HS_KHZ = INT_HS_FREQ_KHZ,
    parameter int unsigned HS_SYS_KHZ = HS_SYS_FREQ_KHZ
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire ccs_wr_t cpu_clock_divider_register_i,
    input wire ccs_wr_t main_clock_mode_register_i,
    input wire ccs_wr_t main_osc_control_register_i,
    input wire ccs_wr_t int_osc_mode_register_i,
    input wire logic int_hs_tick_i,
    input wire logic hs_sys_tick_i,
    input wire logic low_speed_osc_tick_i,
    input wire logic tmr8_out_tick_i,
    input wire logic event_counter_input_pin_i,
    input wire ccs_periph_sel_t periph_sel_i,
    output logic [7:0] cpu_clock_divider_register_o,
    output logic [7:0] main_clock_mode_register_o,
    output logic [7:0] main_osc_control_register_o,
    output logic [7:0] int_osc_mode_register_o,
    output logic cpu_clk_en_o,
    output logic peripheral_clk_o,
    output logic int_hs_osc_stop_o,
    output logic ext_main_osc_stop_o,
    output ccs_periph_en_t periph_clk_en_o
);
    // switch delays in old main clocks, integer division drops the fraction
    localparam int unsigned TO_HS_CYC = 1 + (2 * INT_HS_KHZ) / HS_SYS_KHZ; // [R7] [R8]
    localparam int unsigned TO_INT_CYC = 1 + (2 * HS_SYS_KHZ) / INT_HS_KHZ; // [R7] [R8]
    localparam logic [MSW_CNT_W-1:0] TO_HS_CNT = MSW_CNT_W'(TO_HS_CYC);
    localparam logic [MSW_CNT_W-1:0] TO_INT_CNT = MSW_CNT_W'(TO_INT_CYC);

    typedef struct packed {
        logic [DIV_W-1:0] div_act;
        logic [DIV_W-1:0] div_reg;
        logic [4:0] div_dly;
        logic [3:0] pre_cnt;
        logic sel;
        logic sts;
        logic [MSW_CNT_W-1:0] msw_cnt;
        logic hs_en;
        logic hs_en_locked;
        logic int_stop;
        logic ext_stop;
        logic cpu_en;
        logic main_en;
        ccs_periph_en_t per_en;
    } ccs_state_t;

    ccs_state_t state_q;
    ccs_state_t state_d;

    // cpu clocks to wait, from the setting in force before the write
    function automatic logic [4:0] div_delay(input logic [DIV_W-1:0] sel);
        div_delay = DIV_DLY_BASE >> sel; // [R3]
    endfunction : div_delay

    // main clock ticks per cpu clock minus one
    function automatic logic [3:0] div_last(input logic [DIV_W-1:0] sel);
        logic [4:0] span;
        span = 5'h01 << sel;
        div_last = 4'(span - 5'h01);
    endfunction : div_last

    // two-way source choice used by each peripheral except the watchdog
    function automatic logic pick(input logic alt, input logic a, input logic b);
        pick = alt ? b : a;
    endfunction : pick

    logic main_tick;
    logic cpu_tick;
    logic int_run;

    always_comb begin
        int_run = ~state_q.int_stop;
        // ticks of the source in force; a stopped source gives none
        if (state_q.sts == SRC_HS_SYS) begin // [R5] [R16]
            main_tick = hs_sys_tick_i & ~state_q.ext_stop;
        end else begin
            main_tick = int_hs_tick_i & int_run;
        end
        cpu_tick = main_tick && (state_q.pre_cnt == div_last(state_q.div_act)); // [R1]
    end

    always_comb begin
        state_d = state_q;
        state_d.main_en = main_tick;
        state_d.cpu_en = cpu_tick; // [R17]

        // prescaler runs on the main clock with the active ratio
        if (main_tick) begin
            if (cpu_tick) begin
                state_d.pre_cnt = 4'h0;
            end else begin
                state_d.pre_cnt = state_q.pre_cnt + 4'h1;
            end
        end

        // divider change waits on old cpu clocks
        if (state_q.div_dly != 5'h00 && cpu_tick) begin // [R2]
            state_d.div_dly = state_q.div_dly - 5'h01;
            if (state_q.div_dly == 5'h01) begin
                state_d.div_act = state_q.div_reg; // [R2]
                state_d.pre_cnt = 4'h0; // [R17]
            end
        end
        if (cpu_clock_divider_register_i.wr) begin
            // codes above the largest ratio are not accepted
            if (cpu_clock_divider_register_i.data[DIV_LSB +: DIV_W] <= DIV_MAX) begin // [R1]
                state_d.div_reg = cpu_clock_divider_register_i.data[DIV_LSB +: DIV_W];
                state_d.div_dly = div_delay(state_q.div_act); // [R3]
            end
        end

        // main source switch counts old main clocks
        if (state_q.msw_cnt != '0 && main_tick) begin // [R5]
            state_d.msw_cnt = state_q.msw_cnt - MSW_CNT_W'(1);
            if (state_q.msw_cnt == MSW_CNT_W'(1)) begin
                state_d.sts = state_q.sel; // [R6]
                state_d.pre_cnt = 4'h0; // [R17]
            end
        end
        if (main_clock_mode_register_i.wr) begin
            state_d.sel = main_clock_mode_register_i.data[MCM_SEL_BIT]; // [R4]
            if (main_clock_mode_register_i.data[MCM_SEL_BIT] == state_q.sts) begin
                state_d.msw_cnt = '0;
            end else if (state_q.sts == SRC_INT_HS) begin
                state_d.msw_cnt = TO_HS_CNT; // [R7]
            end else begin
                state_d.msw_cnt = TO_INT_CNT; // [R7]
            end
            // high-speed enable may change once, then it is frozen
            if (!state_q.hs_en_locked
                && main_clock_mode_register_i.data[MCM_HSEN_BIT] != state_q.hs_en) begin // [R10]
                state_d.hs_en = main_clock_mode_register_i.data[MCM_HSEN_BIT];
                state_d.hs_en_locked = 1'b1; // [R10]
            end
        end

        if (main_osc_control_register_i.wr) begin
            state_d.ext_stop = main_osc_control_register_i.data[MOC_STOP_BIT]; // [R14]
        end
        if (int_osc_mode_register_i.wr) begin
            state_d.int_stop = int_osc_mode_register_i.data[RCM_STOP_BIT]; // [R15]
        end

        // peripheral sources follow the fixed choice table
        state_d.per_en.wdt = low_speed_osc_tick_i; // [R13]
        state_d.per_en.tmr8_h1 = pick(periph_sel_i.tmr8_h1_use_lowspd,
                                      main_tick, low_speed_osc_tick_i); // [R13]
        state_d.per_en.tmr8_h0 = pick(periph_sel_i.tmr8_h0_use_t8out,
                                      main_tick, tmr8_out_tick_i); // [R13]
        state_d.per_en.serial = pick(periph_sel_i.serial_use_t8out,
                                     main_tick, tmr8_out_tick_i); // [R13]
        state_d.per_en.evt_cnt = pick(periph_sel_i.evt_cnt_use_pin,
                                      main_tick, event_counter_input_pin_i); // [R13]
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q.div_act <= DIV_RST;
            state_q.div_reg <= DIV_RST;
            state_q.div_dly <= 5'h00;
            state_q.pre_cnt <= 4'h0;
            state_q.sel <= MCM_SEL_RST; // [R16]
            state_q.sts <= SRC_INT_HS; // [R16]
            state_q.msw_cnt <= '0;
            state_q.hs_en <= MCM_HSEN_RST;
            state_q.hs_en_locked <= 1'b0;
            state_q.int_stop <= RCM_STOP_RST;
            state_q.ext_stop <= MOC_STOP_RST;
            state_q.cpu_en <= 1'b0;
            state_q.main_en <= 1'b0;
            state_q.per_en <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        cpu_clock_divider_register_o = 8'h00;
        cpu_clock_divider_register_o[DIV_LSB +: DIV_W] = state_q.div_reg;
        main_clock_mode_register_o = 8'h00;
        main_clock_mode_register_o[MCM_SEL_BIT] = state_q.sel;
        main_clock_mode_register_o[MCM_STS_BIT] = state_q.sts; // [R6]
        main_clock_mode_register_o[MCM_HSEN_BIT] = state_q.hs_en;
        main_osc_control_register_o = 8'h00;
        main_osc_control_register_o[MOC_STOP_BIT] = state_q.ext_stop;
        int_osc_mode_register_o = 8'h00;
        int_osc_mode_register_o[RCM_STOP_BIT] = state_q.int_stop;
        int_osc_mode_register_o[RCM_RUN_BIT] = ~state_q.int_stop; // [R15]
    end

    assign cpu_clk_en_o = state_q.cpu_en;
    assign peripheral_clk_o = state_q.main_en;
    assign int_hs_osc_stop_o = state_q.int_stop;
    assign ext_main_osc_stop_o = state_q.ext_stop;
    assign periph_clk_en_o = state_q.per_en;
endmodule : ccs_clock_switch

// file: tb/ccs_clock_switch_checker.sv
// Purpose: port-level checks for the cpu clock switch
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the switch
`timescale 1ns/1ns
module ccs_clock_switch_checker
    import ccs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire ccs_wr_t main_clock_mode_register_i,
    input wire logic low_speed_osc_tick_i,
    input wire logic [7:0] cpu_clock_divider_register_o,
    input wire logic [7:0] main_clock_mode_register_o,
    input wire logic [7:0] main_osc_control_register_o,
    input wire logic [7:0] int_osc_mode_register_o,
    input wire logic cpu_clk_en_o,
    input wire logic peripheral_clk_o,
    input wire logic int_hs_osc_stop_o,
    input wire logic ext_main_osc_stop_o,
    input wire ccs_periph_en_t periph_clk_en_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_div;
        cpu_clock_divider_register_o <= 8'h04;
    endproperty
    a_div: assert property (p_div) else $error("divider code out of range");
    property p_sel;
        main_clock_mode_register_i.wr |=>
            main_clock_mode_register_o[0] == $past(main_clock_mode_register_i.data[0]);
    endproperty
    a_sel: assert property (p_sel) else $error("select bit not taken");
    property p_sts;
        $changed(main_clock_mode_register_o[1]) |->
            main_clock_mode_register_o[1] == $past(main_clock_mode_register_o[0]);
    endproperty
    a_sts: assert property (p_sts) else $error("status moved off select");
    property p_hsen;
        main_clock_mode_register_o[2] |=> main_clock_mode_register_o[2];
    endproperty
    a_hsen: assert property (p_hsen) else $error("enable changed twice");
    property p_run;
        int_osc_mode_register_o[7] != int_osc_mode_register_o[0];
    endproperty
    a_run: assert property (p_run) else $error("running flag wrong");
    property p_stop;
        int_hs_osc_stop_o == int_osc_mode_register_o[0]
            && ext_main_osc_stop_o == main_osc_control_register_o[7];
    endproperty
    a_stop: assert property (p_stop) else $error("stop outputs off flags");
    property p_wdt;
        $past(rst_n_i) |-> periph_clk_en_o.wdt == $past(low_speed_osc_tick_i);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clock wrong");
    property p_cpu;
        cpu_clk_en_o |-> peripheral_clk_o;
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu pulse without main tick");
    c_up: cover property ($rose(main_clock_mode_register_o[1]));
    c_dn: cover property ($fell(main_clock_mode_register_o[1]));
    c_div: cover property (cpu_clock_divider_register_o == 8'h01);
endmodule : ccs_clock_switch_checker

bind ccs_clock_switch ccs_clock_switch_checker i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .main_clock_mode_register_i(main_clock_mode_register_i),
    .low_speed_osc_tick_i(low_speed_osc_tick_i),
    .cpu_clock_divider_register_o(cpu_clock_divider_register_o),
    .main_clock_mode_register_o(main_clock_mode_register_o),
    .main_osc_control_register_o(main_osc_control_register_o),
    .int_osc_mode_register_o(int_osc_mode_register_o), .cpu_clk_en_o(cpu_clk_en_o),
    .peripheral_clk_o(peripheral_clk_o), .int_hs_osc_stop_o(int_hs_osc_stop_o),
    .ext_main_osc_stop_o(ext_main_osc_stop_o), .periph_clk_en_o(periph_clk_en_o));

// file: tb/ccs_clock_switch_tb.sv
// Purpose: directed bench for the cpu clock switch
// Assumes: both oscillators tick every cycle
// Notes: registers 0..3 are divider, mode, main osc, int osc
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module ccs_clock_switch_tb;
    import ccs_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    ccs_wr_t wr_q [4] = '{default: '0};
    logic [3:0] cnt_q = 4'h0;
    logic lsp_q = 1'b0;
    logic lsp_p = 1'b0;
    logic t8_p = 1'b0;
    logic pin_p = 1'b0;
    ccs_periph_sel_t psel_q = 4'h5;
    logic [7:0] div_o, mcm_o, moc_o, rcm_o;
    logic cpu_en, per_clk, int_stop, ext_stop;
    ccs_periph_en_t pen;
    int mismatches = 0;
    int checks = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cnt_q <= cnt_q + 4'h1;
        lsp_q <= (cnt_q == 4'hf);
        // source values as the switch sampled them at this edge
        lsp_p <= lsp_q;
        t8_p <= cnt_q[0];
        pin_p <= cnt_q[1];
    end
    ccs_clock_switch i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .cpu_clock_divider_register_i(wr_q[0]), .main_clock_mode_register_i(wr_q[1]),
        .main_osc_control_register_i(wr_q[2]), .int_osc_mode_register_i(wr_q[3]),
        .int_hs_tick_i(1'b1), .hs_sys_tick_i(1'b1), .low_speed_osc_tick_i(lsp_q),
        .tmr8_out_tick_i(cnt_q[0]), .event_counter_input_pin_i(cnt_q[1]),
        .periph_sel_i(psel_q), .cpu_clock_divider_register_o(div_o),
        .main_clock_mode_register_o(mcm_o), .main_osc_control_register_o(moc_o),
        .int_osc_mode_register_o(rcm_o), .cpu_clk_en_o(cpu_en), .peripheral_clk_o(per_clk),
        .int_hs_osc_stop_o(int_stop), .ext_main_osc_stop_o(ext_stop), .periph_clk_en_o(pen));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc
    task automatic wr_reg(input int r, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_q[r] <= '{wr: 1'b1, data: d};
        @(posedge clk_sys_i);
        wr_q[r].wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic t_periph;
        repeat (16) begin
            cyc(1);
            `CHK("main tick", 1'b1, per_clk)
            `CHK("wdt src", lsp_p, pen.wdt)
            `CHK("h1 lowspd", lsp_p, pen.tmr8_h1)
            `CHK("serial t8", t8_p, pen.serial)
            `CHK("h0 main", per_clk, pen.tmr8_h0)
            `CHK("evt main", per_clk, pen.evt_cnt)
        end
        @(posedge clk_sys_i);
        psel_q <= 4'ha;
        cyc(1);
        repeat (16) begin
            cyc(1);
            `CHK("h0 t8", t8_p, pen.tmr8_h0)
            `CHK("evt pin", pin_p, pen.evt_cnt)
            `CHK("h1 main", per_clk, pen.tmr8_h1)
            `CHK("serial main", per_clk, pen.serial)
        end
    endtask : t_periph
    task automatic wait_sts(input logic v, output int n);
        n = 0;
        while (mcm_o[1] !== v && n < 20) begin
            cyc(1);
            n++;
        end
        if (n == 20) begin
            `CHK("status wait", v, mcm_o[1])
            finish_test();
        end
    endtask : wait_sts
    task automatic t_reset;
        #1;
        `CHK("div rst", 8'h00, div_o)
        `CHK("mode rst", 8'h00, mcm_o)
        `CHK("moc rst", 8'h80, moc_o)
        `CHK("rcm rst", 8'h80, rcm_o)
    endtask : t_reset
    task automatic t_div;
        int n;
        wr_reg(0, 8'h01);
        n = 0;
        repeat (14) begin
            cyc(1);
            n += cpu_en;
        end
        `CHK("old ratio pulses", 14, n)
        cyc(4);
        n = 0;
        repeat (20) begin
            cyc(1);
            n += cpu_en;
        end
        `CHK("new ratio pulses", 10, n)
        wr_reg(0, 8'h05);
        `CHK("bad code kept", 8'h01, div_o)
    endtask : t_div
    task automatic t_main;
        int n;
        wr_reg(2, 8'h00);
        `CHK("ext run", 1'b0, ext_stop)
        wr_reg(1, 8'h04);
        wr_reg(1, 8'h05);
        wait_sts(1'b1, n);
        `CHK("up delay", 1'b1, n < 3)
        wr_reg(3, 8'h01);
        `CHK("int stop", 1'b1, int_stop)
        `CHK("rcm stop", 8'h01, rcm_o)
        wr_reg(3, 8'h00);
        wr_reg(1, 8'h04);
        wait_sts(1'b0, n);
        `CHK("down delay", 1'b1, n >= 8 && n <= 11)
        wr_reg(2, 8'h80);
        `CHK("ext stop", 1'b1, ext_stop)
        wr_reg(1, 8'h00);
        `CHK("enable locked", 8'h04, mcm_o)
    endtask : t_main
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_div();
        t_periph();
        t_main();
        finish_test();
    end
endmodule : ccs_clock_switch_tb
